// ---- ejt_exec.sv ----
// Purpose: decode/execute for sign extend, forced trap, jump, call, lea
// Assumes: effective address is computed outside and given with the word
// Notes: one word per accepted request; trap stacking takes several cycles
//
// What this block does
// - opmode picks byte-word, word-long, byte-long extension
// - low register field names extended data register
// - sign fill; n,z from result; v,c cleared
// - forced-trap opcode raises vector 4 exception
// - push offset word, pc, status; load vector
// - reduced variant skips offset word push
// - jump loads pc from effective address
// - only control modes accepted for these ops
// - mode 111 qualified by register 000 to 011
// - full-format modes; reduced 32-bit variant no indirection
// - call pushes return address, then jumps
// - lea writes full 32-bit address to register
// - bits 11..9 select destination address register
`timescale 1ns/1ns
module ejt_exec (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic reduced_core_i,
  input wire logic reduced32_core_i,
  input wire logic op_valid_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] ext_word_i,
  input wire logic [31:0] ea_addr_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] data_reg_i,
  input wire logic [15:0] status_word_i,
  input wire logic mem_ready_i,
  output logic op_ready_o,
  output logic [2:0] data_reg_sel_o,
  output logic data_reg_we_o,
  output logic [31:0] data_reg_wdata_o,
  output logic address_reg_we_o,
  output logic [2:0] address_reg_sel_o,
  output logic [31:0] address_reg_wdata_o,
  output logic [4:0] ccr_o,
  output logic pc_load_o,
  output logic [31:0] pc_o,
  output logic [31:0] sp_o,
  output logic [31:0] supervisor_stack_pointer_o,
  output ejt_pkg::ejt_mem_wr_t mem_wr_o,
  output logic vec_fetch_o,
  output logic [7:0] vec_num_o,
  output logic [31:0] vec_addr_o,
  output logic illegal_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_OFS = 3'b001,
    ST_PUSH_PC = 3'b010,
    ST_PUSH_SR = 3'b011,
    ST_VECTOR = 3'b100,
    ST_CALL = 3'b101
  } ejt_state_t;

  ejt_state_t state;
  ejt_state_t next_state;
  logic [31:0] trap_pc;
  logic [15:0] trap_sr;
  logic [31:0] call_target;
  logic [31:0] ext_result;
  logic [4:0] ext_ccr;
  logic is_ext;
  logic is_trap;
  logic is_jmp;
  logic is_call;
  logic is_lea;
  logic ea_ok;
  logic take;
  logic go_trap;
  logic wr_done;

  // control-mode legality check, shared by jump, call and lea
  function automatic logic ea_control_ok(input logic [5:0] ea,
                                         input logic [15:0] ext,
                                         input logic red32);
    logic ok;
    logic idx_form;
    ok = 1'b0;
    idx_form = 1'b0;
    unique case (ea[5:3])
      ejt_pkg::MODE_IND, ejt_pkg::MODE_DISP: ok = 1'b1;
      ejt_pkg::MODE_IDX: idx_form = 1'b1;
      ejt_pkg::MODE_EXT: begin
        ok = (ea[2:0] == ejt_pkg::REG_ABS_W) ||
             (ea[2:0] == ejt_pkg::REG_ABS_L) ||
             (ea[2:0] == ejt_pkg::REG_PC_D16);
        idx_form = (ea[2:0] == ejt_pkg::REG_PC_IDX);
      end
      default: ok = 1'b0; // direct, postinc, predec rejected
    endcase
    // reduced 32-bit core has no memory-indirect full format
    if (idx_form) begin
      ok = !(red32 && ext[ejt_pkg::FULL_FMT_BIT] &&
             (ext[2:0] != 3'h0));
    end
    return ok;
  endfunction

  always_comb begin
    is_ext = ((opcode_i & ejt_pkg::EXT_MASK) == ejt_pkg::EXT_MATCH) &&
             ((opcode_i[8:6] == ejt_pkg::OPM_B2W) ||
              (opcode_i[8:6] == ejt_pkg::OPM_W2L) ||
              (opcode_i[8:6] == ejt_pkg::OPM_B2L));
    is_trap = (opcode_i == ejt_pkg::TRAP_OPCODE);
    is_jmp = ((opcode_i & ejt_pkg::JMP_MASK) == ejt_pkg::JMP_MATCH);
    is_call = ((opcode_i & ejt_pkg::JMP_MASK) == ejt_pkg::CALL_MATCH);
    // byte-to-long extend shares the lea pattern with a data-reg ea
    is_lea = ((opcode_i & ejt_pkg::LEA_MASK) == ejt_pkg::LEA_MATCH) &&
             !is_ext;
    ea_ok = ea_control_ok(opcode_i[5:0], ext_word_i, reduced32_core_i);
    take = ce_i && op_valid_i && op_ready_o;
    go_trap = is_trap || ((is_jmp || is_call || is_lea) && !ea_ok);
  end

  ejt_sign_ext u_sign_ext (
    .opmode_i(opcode_i[8:6]),
    .req_i('{ccr_in: status_word_i[4:0], data_in: data_reg_i}),
    .result_o(ext_result),
    .ccr_o(ext_ccr)
  );

  assign wr_done = mem_wr_o.valid && mem_ready_i;

  // sequencer: trap stacking and call push wait on memory ready
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (take && go_trap) begin
          // earliest variant has no format word to push
          next_state = reduced_core_i ? ST_PUSH_PC
                                      : ST_PUSH_OFS;
        end else if (take && is_call && ea_ok) begin
          next_state = ST_CALL;
        end
      end
      ST_PUSH_OFS: if (wr_done) next_state = ST_PUSH_PC;
      ST_PUSH_PC: if (wr_done) next_state = ST_PUSH_SR;
      ST_PUSH_SR: if (wr_done) next_state = ST_VECTOR;
      ST_VECTOR: next_state = ST_IDLE;
      ST_CALL: if (wr_done) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // latch context of a trap or call when accepted
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      trap_pc <= ejt_pkg::PC_RESET;
      trap_sr <= 16'h0000;
      call_target <= ejt_pkg::PC_RESET;
    end else if (take) begin
      trap_pc <= next_pc_i;
      trap_sr <= status_word_i; // stacked copy only
      call_target <= ea_addr_i;
    end
  end

  // stack pointers and memory write port
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      supervisor_stack_pointer_o <= ejt_pkg::SP_RESET;
      sp_o <= ejt_pkg::SP_RESET;
      mem_wr_o <= '0;
    end else if (ce_i) begin
      if (wr_done) begin
        mem_wr_o.valid <= 1'b0;
      end
      if (state == ST_IDLE && take && go_trap) begin
        mem_wr_o.valid <= 1'b1;
        mem_wr_o.is_long <= reduced_core_i;
        if (reduced_core_i) begin
          mem_wr_o.addr <= supervisor_stack_pointer_o - ejt_pkg::STEP_LONG;
          mem_wr_o.data <= next_pc_i;
          supervisor_stack_pointer_o <= supervisor_stack_pointer_o -
                                        ejt_pkg::STEP_LONG;
        end else begin
          // offset word is vector times four, format zero
          mem_wr_o.addr <= supervisor_stack_pointer_o - ejt_pkg::STEP_WORD;
          mem_wr_o.data <= {22'h0, ejt_pkg::ILLEGAL_VECTOR, 2'b00};
          supervisor_stack_pointer_o <= supervisor_stack_pointer_o -
                                        ejt_pkg::STEP_WORD;
        end
      end else if (state == ST_IDLE && take && is_call && ea_ok) begin
        mem_wr_o.valid <= 1'b1;
        mem_wr_o.is_long <= 1'b1;
        mem_wr_o.addr <= sp_o - ejt_pkg::STEP_LONG;
        mem_wr_o.data <= next_pc_i;
        sp_o <= sp_o - ejt_pkg::STEP_LONG;
      end else if (wr_done && state == ST_PUSH_OFS) begin
        mem_wr_o.valid <= 1'b1;
        mem_wr_o.is_long <= 1'b1;
        mem_wr_o.addr <= supervisor_stack_pointer_o - ejt_pkg::STEP_LONG;
        mem_wr_o.data <= trap_pc;
        supervisor_stack_pointer_o <= supervisor_stack_pointer_o -
                                      ejt_pkg::STEP_LONG;
      end else if (wr_done && state == ST_PUSH_PC) begin
        mem_wr_o.valid <= 1'b1;
        mem_wr_o.is_long <= 1'b0;
        mem_wr_o.addr <= supervisor_stack_pointer_o - ejt_pkg::STEP_WORD;
        mem_wr_o.data <= {16'h0000, trap_sr};
        supervisor_stack_pointer_o <= supervisor_stack_pointer_o -
                                      ejt_pkg::STEP_WORD;
      end
    end
  end

  // program counter, vector fetch and ready handshake
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pc_load_o <= 1'b0;
      pc_o <= ejt_pkg::PC_RESET;
      vec_fetch_o <= 1'b0;
      vec_num_o <= 8'h00;
      vec_addr_o <= ejt_pkg::VBR_RESET;
      illegal_o <= 1'b0;
      op_ready_o <= 1'b0;
    end else if (ce_i) begin
      pc_load_o <= 1'b0;
      vec_fetch_o <= 1'b0;
      illegal_o <= 1'b0;
      op_ready_o <= (next_state == ST_IDLE) && !take;
      if (state == ST_IDLE && take && go_trap) begin
        illegal_o <= 1'b1;
        vec_num_o <= ejt_pkg::ILLEGAL_VECTOR;
      end else if (state == ST_IDLE && take && is_jmp) begin
        pc_load_o <= 1'b1;
        pc_o <= ea_addr_i;
      end else if (state == ST_VECTOR) begin
        vec_fetch_o <= 1'b1;
        vec_addr_o <= ejt_pkg::VBR_RESET +
                      {22'h0, ejt_pkg::ILLEGAL_VECTOR, 2'b00};
      end else if (state == ST_CALL && wr_done) begin
        pc_load_o <= 1'b1;
        pc_o <= call_target;
      end
    end
  end

  // register file writes; flags only change on sign extension
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_reg_we_o <= 1'b0;
      data_reg_sel_o <= 3'h0;
      data_reg_wdata_o <= 32'h0000_0000;
      address_reg_we_o <= 1'b0;
      address_reg_sel_o <= 3'h0;
      address_reg_wdata_o <= 32'h0000_0000;
      ccr_o <= ejt_pkg::CCR_RESET;
    end else if (ce_i) begin
      data_reg_we_o <= 1'b0;
      address_reg_we_o <= 1'b0;
      data_reg_sel_o <= opcode_i[2:0];
      if (state == ST_IDLE && take && is_ext) begin
        data_reg_we_o <= 1'b1;
        data_reg_wdata_o <= ext_result;
        ccr_o <= ext_ccr;
      end else if (state == ST_IDLE && take && is_lea && ea_ok) begin
        address_reg_we_o <= 1'b1;
        address_reg_sel_o <= opcode_i[11:9];
        address_reg_wdata_o <= ea_addr_i;
      end
    end
  end
endmodule // ejt_exec

// ---- ejt_pkg.sv ----
// Purpose: shared constants and carriers for the jump/trap/extend executor
// Assumes: 16-bit opcode words, 32-bit registers and addresses
// Notes: no software-visible registers
package ejt_pkg;
  localparam logic [15:0] TRAP_OPCODE = 16'h4afc;
  localparam logic [15:0] EXT_MASK = 16'hfe38;
  localparam logic [15:0] EXT_MATCH = 16'h4800;
  localparam logic [15:0] JMP_MASK = 16'hffc0;
  localparam logic [15:0] JMP_MATCH = 16'h4ec0;
  localparam logic [15:0] CALL_MATCH = 16'h4e80;
  localparam logic [15:0] LEA_MASK = 16'hf1c0;
  localparam logic [15:0] LEA_MATCH = 16'h41c0;
  localparam logic [2:0] OPM_B2W = 3'h2;
  localparam logic [2:0] OPM_W2L = 3'h3;
  localparam logic [2:0] OPM_B2L = 3'h7;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_DISP = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_ABS_W = 3'h0;
  localparam logic [2:0] REG_ABS_L = 3'h1;
  localparam logic [2:0] REG_PC_D16 = 3'h2;
  localparam logic [2:0] REG_PC_IDX = 3'h3;
  localparam int OPM_LSB = 6;
  localparam int AREG_LSB = 9;
  localparam int EA_MODE_LSB = 3;
  localparam int FULL_FMT_BIT = 8;
  localparam int INDIRECT_LSB = 0;
  localparam logic [7:0] ILLEGAL_VECTOR = 8'h04;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [4:0] CCR_RESET = 5'h00;

  typedef struct packed {
    logic [4:0] ccr_in; // x n z v c
    logic [31:0] data_in;
  } ejt_ext_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic is_long;
  } ejt_mem_wr_t;
endpackage

// ---- ejt_sign_ext.sv ----
// Purpose: sign-extension datapath with flag update
// Assumes: opmode already known to be one of the three legal codes
// Notes: purely combinational
`timescale 1ns/1ns
module ejt_sign_ext (
  input wire logic [2:0] opmode_i,
  input wire ejt_pkg::ejt_ext_req_t req_i,
  output logic [31:0] result_o,
  output logic [4:0] ccr_o
);
  logic neg;
  logic zero;

  // replicate the sign bit up to the destination width
  always_comb begin
    result_o = req_i.data_in;
    neg = 1'b0;
    zero = 1'b0;
    unique case (opmode_i)
      ejt_pkg::OPM_B2W: begin
        result_o = {req_i.data_in[31:16], {8{req_i.data_in[7]}},
                    req_i.data_in[7:0]};
        neg = req_i.data_in[7];
        zero = (req_i.data_in[7:0] == 8'h00);
      end
      ejt_pkg::OPM_W2L: begin
        result_o = {{16{req_i.data_in[15]}}, req_i.data_in[15:0]};
        neg = req_i.data_in[15];
        zero = (req_i.data_in[15:0] == 16'h0000);
      end
      ejt_pkg::OPM_B2L: begin
        result_o = {{24{req_i.data_in[7]}}, req_i.data_in[7:0]};
        neg = req_i.data_in[7];
        zero = (req_i.data_in[7:0] == 8'h00);
      end
      default: begin
        result_o = req_i.data_in;
      end
    endcase
    // x kept, v and c cleared
    ccr_o = {req_i.ccr_in[4], neg, zero, 2'b00};
  end
endmodule // ejt_sign_ext

// ---- ejt_exec_asserts.sv ----
// Purpose: port-level checks for ejt_exec
// Assumes: ce_i held high while ops are in flight
// Notes: bind sits after the module
`timescale 1ns/1ns
module ejt_exec_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic reduced_core_i,
  input wire logic op_valid_i,
  input wire logic [15:0] opcode_i,
  input wire logic [31:0] ea_addr_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [15:0] status_word_i,
  input wire logic mem_ready_i,
  input wire logic op_ready_o,
  input wire logic [2:0] data_reg_sel_o,
  input wire logic data_reg_we_o,
  input wire logic address_reg_we_o,
  input wire logic [2:0] address_reg_sel_o,
  input wire logic [31:0] address_reg_wdata_o,
  input wire logic [4:0] ccr_o,
  input wire logic pc_load_o,
  input wire logic [31:0] pc_o,
  input wire logic [31:0] sp_o,
  input wire logic [31:0] supervisor_stack_pointer_o,
  input wire ejt_pkg::ejt_mem_wr_t mem_wr_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic tk, jump_op, cal, load_address_op, ext, bad, ok, pend;
  logic [31:0] pend_ea;
  // decode; ext wins over the lea pattern it overlaps
  assign tk = ce_i && op_valid_i && op_ready_o;
  assign jump_op = (opcode_i & ejt_pkg::JMP_MASK) == ejt_pkg::JMP_MATCH;
  assign cal = (opcode_i & ejt_pkg::JMP_MASK) == ejt_pkg::CALL_MATCH;
  assign ext = (opcode_i & ejt_pkg::EXT_MASK) == ejt_pkg::EXT_MATCH
    && opcode_i[8:6] inside {3'h2, 3'h3, 3'h7};
  assign load_address_op = (opcode_i & ejt_pkg::LEA_MASK) == ejt_pkg::LEA_MATCH && !ext;
  assign bad = !(opcode_i[5:3] inside {3'h2, 3'h5, 3'h6})
    && !(opcode_i[5:3] == 3'h7 && opcode_i[2:0] < 3'h4);
  // indexed mode left out: its legality hangs on the extension word
  assign ok = !bad && opcode_i[5:3] != 3'h6;
  // remembers a call between its push and its jump
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || pc_load_o) begin
      pend <= 1'b0;
    end else if (tk && cal && ok) begin
      pend <= 1'b1;
      pend_ea <= ea_addr_i;
    end
  end
  sequence s_call_take;
    tk && cal && ok;
  endsequence
  sequence s_push_done;
    mem_wr_o.valid && mem_ready_i;
  endsequence
  jump_pc_a: assert property (
    tk && jump_op && ok |=> pc_load_o && pc_o == $past(ea_addr_i)
    && !mem_wr_o.valid) else $error("jump did not load pc");
  lea_load_a: assert property (
    tk && load_address_op && ok |=> address_reg_we_o
    && address_reg_wdata_o == $past(ea_addr_i)
    && address_reg_sel_o == $past(opcode_i[11:9]))
    else $error("lea write wrong");
  ext_select_a: assert property (
    tk && ext |=> data_reg_we_o && data_reg_sel_o == $past(opcode_i[2:0]))
    else $error("extend register wrong");
  ext_flags_a: assert property (
    tk && ext |=> ccr_o[1:0] == 2'h0 && ccr_o[4] == $past(status_word_i[4]))
    else $error("extend flags wrong");
  call_push_a: assert property (
    s_call_take |=> mem_wr_o.valid && mem_wr_o.is_long
    && mem_wr_o.addr == $past(sp_o) - 32'h4
    && mem_wr_o.data == $past(next_pc_i)) else $error("call push wrong");
  call_jump_a: assert property (
    (pend and s_push_done) |=> pc_load_o && pc_o == pend_ea)
    else $error("call jump wrong");
  trap_push_a: assert property (
    tk && opcode_i == ejt_pkg::TRAP_OPCODE |=> illegal_o && mem_wr_o.valid
    && mem_wr_o.addr == $past(supervisor_stack_pointer_o)
    - ($past(reduced_core_i) ? 32'h4 : 32'h2)) else $error("trap start wrong");
  bad_ea_a: assert property (
    tk && (jump_op || cal || load_address_op) && bad |=> illegal_o && mem_wr_o.valid)
    else $error("bad mode not trapped");
  flags_keep_a: assert property (
    tk && (jump_op || cal || load_address_op || opcode_i == ejt_pkg::TRAP_OPCODE)
    |=> $stable(ccr_o)) else $error("flags changed");
  push_hold_a: assert property (
    mem_wr_o.valid && !mem_ready_i |=> $stable(mem_wr_o))
    else $error("push dropped before ready");
endmodule // ejt_exec_asserts
bind ejt_exec ejt_exec_asserts u_chk (.mclk_i, .rst_n_i, .ce_i,
  .reduced_core_i, .op_valid_i, .opcode_i, .ea_addr_i, .next_pc_i,
  .status_word_i, .mem_ready_i, .op_ready_o, .data_reg_sel_o,
  .data_reg_we_o, .address_reg_we_o, .address_reg_sel_o,
  .address_reg_wdata_o, .ccr_o, .pc_load_o, .pc_o, .sp_o,
  .supervisor_stack_pointer_o, .mem_wr_o, .illegal_o);

// ---- ejt_stack_model.sv ----
// Purpose: stack memory beside the executor
// Assumes: one write outstanding at a time
// Notes: accepted writes are queued for the bench
`timescale 1ns/1ns
module ejt_stack_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire ejt_pkg::ejt_mem_wr_t mem_wr_i,
  input wire logic [3:0] delay_i,
  output logic mem_ready_o = 1'b0
);
  logic [3:0] wait_cnt = 4'h0;
  ejt_pkg::ejt_mem_wr_t log_q[$];
  // ready is a one-cycle pulse after delay_i waiting cycles
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mem_ready_o <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      mem_ready_o <= mem_wr_i.valid && !mem_ready_o && wait_cnt >= delay_i;
      wait_cnt <= (mem_wr_i.valid && !mem_ready_o) ? wait_cnt + 4'h1 : 4'h0;
      if (mem_wr_i.valid && mem_ready_o) log_q.push_back(mem_wr_i);
    end
  end
endmodule // ejt_stack_model

// ---- ejt_exec_bench.sv ----
// Purpose: self-checking bench for ejt_exec
// Assumes: stack model answers every push
// Notes: inputs change on falling edges only
`timescale 1ns/1ns
module ejt_exec_bench;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] din;
    logic [31:0] dout;
    logic [4:0] ccr;
  } ejt_row_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic reduced_core_i = 1'b0;
  logic reduced32_core_i = 1'b0;
  logic op_valid_i = 1'b0;
  logic [15:0] opcode_i = 16'h0, ext_word_i = 16'h0, status_word_i = 16'h2013;
  logic [31:0] ea_addr_i = 32'h0, next_pc_i = 32'h0, data_reg_i = 32'h0;
  logic [3:0] delay_i = 4'h0;
  logic mem_ready_i, op_ready_o, data_reg_we_o, address_reg_we_o;
  logic pc_load_o, vec_fetch_o, illegal_o;
  logic [2:0] data_reg_sel_o, address_reg_sel_o;
  logic [31:0] data_reg_wdata_o, address_reg_wdata_o, pc_o, sp_o;
  logic [31:0] supervisor_stack_pointer_o, vec_addr_o;
  logic [4:0] ccr_o;
  logic [7:0] vec_num_o;
  ejt_pkg::ejt_mem_wr_t mem_wr_o;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  ejt_row_t rows [4] = '{
    '{16'h4880, 32'h1234_5680, 32'h1234_ff80, 5'h18},
    '{16'h48c3, 32'hffff_7fff, 32'h0000_7fff, 5'h10},
    '{16'h49c5, 32'h0000_1200, 32'h0000_0000, 5'h14},
    '{16'h4882, 32'hffff_0000, 32'hffff_0000, 5'h14}};
  logic [15:0] good [7] = '{16'h10, 16'h2d, 16'h36, 16'h38, 16'h39,
    16'h3a, 16'h3b};
  logic [15:0] bad [6] = '{16'h00, 16'h09, 16'h1a, 16'h23, 16'h3c, 16'h3f};
  ejt_exec DUT (.mclk_i, .rst_n_i, .ce_i, .reduced_core_i, .reduced32_core_i,
    .op_valid_i, .opcode_i, .ext_word_i, .ea_addr_i, .next_pc_i, .data_reg_i,
    .status_word_i, .mem_ready_i, .op_ready_o, .data_reg_sel_o,
    .data_reg_we_o, .data_reg_wdata_o, .address_reg_we_o, .address_reg_sel_o,
    .address_reg_wdata_o, .ccr_o, .pc_load_o, .pc_o, .sp_o,
    .supervisor_stack_pointer_o, .mem_wr_o, .vec_fetch_o, .vec_num_o,
    .vec_addr_o, .illegal_o);
  ejt_stack_model u_mem (.mclk_i, .rst_n_i, .mem_wr_i(mem_wr_o), .delay_i,
    .mem_ready_o(mem_ready_i));
  // 4 ns period
  initial forever #2 mclk_i = ~mclk_i;
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // waits for ready, holds valid over one edge; returns while pulses stand
  task automatic issue(input logic [15:0] op, input logic [31:0] a);
    int n = 0;
    @(negedge mclk_i);
    while (op_ready_o !== 1'b1 && n < 60) begin
      @(negedge mclk_i);
      n++;
    end
    opcode_i = op;
    ea_addr_i = a;
    op_valid_i = 1'b1;
    @(negedge mclk_i);
    op_valid_i = 1'b0;
  endtask
  task automatic trap_chk(input logic [15:0] op, input logic red);
    logic [31:0] s;
    logic [4:0] f;
    ejt_pkg::ejt_mem_wr_t w;
    int n = 0;
    reduced_core_i = red;
    next_pc_i = {16'h0000, op};
    s = supervisor_stack_pointer_o;
    f = ccr_o;
    u_mem.log_q.delete();
    issue(op, 32'h0);
    chk("illegal", 1'b1, illegal_o);
    while (vec_fetch_o !== 1'b1 && n < 80) begin
      @(negedge mclk_i);
      n++;
    end
    chk("vec fetch", 1'b1, vec_fetch_o);
    chk("vec addr", 32'h10, vec_addr_o);
    chk("vec num", 8'h4, vec_num_o);
    chk("flags", f, ccr_o);
    chk("ssp", s - (red ? 32'h6 : 32'h8), supervisor_stack_pointer_o);
    chk("pushes", red ? 2 : 3, u_mem.log_q.size());
    if (!red) begin
      w = u_mem.log_q.pop_front();
      chk("offset addr", s - 32'h2, w.addr);
      chk("offset data", 32'h10, w.data);
    end
    w = u_mem.log_q.pop_front();
    chk("pc addr", s - (red ? 32'h4 : 32'h6), w.addr);
    chk("pc long", 1'b1, w.is_long);
    chk("pc data", {16'h0000, op}, w.data);
    w = u_mem.log_q.pop_front();
    chk("sr addr", s - (red ? 32'h6 : 32'h8), w.addr);
    chk("sr data", status_word_i, w.data[15:0]);
  endtask
  initial begin
    logic [31:0] s;
    ejt_pkg::ejt_mem_wr_t w;
    int n;
    repeat (3) @(negedge mclk_i);
    chk("ready in reset", 1'b0, op_ready_o);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    chk("ready after reset", 1'b1, op_ready_o);
    chk("pc after reset", 32'h0, pc_o);
    foreach (rows[i]) begin
      data_reg_i = rows[i].din;
      issue(rows[i].op, 32'h0);
      chk("ext data", rows[i].dout, data_reg_wdata_o);
      chk("ext sel", rows[i].op[2:0], data_reg_sel_o);
      chk("ext we", 1'b1, data_reg_we_o);
      chk("ext flags", rows[i].ccr, ccr_o);
    end
    foreach (good[i]) begin
      issue(ejt_pkg::JMP_MATCH | good[i], 32'h8765_4320 + i);
      chk("jump load", 1'b1, pc_load_o);
      chk("jump pc", 32'h8765_4320 + i, pc_o);
      issue(ejt_pkg::LEA_MATCH | {4'h0, i[2:0], 9'h0} | good[i], 32'hf0e0_0000 + i);
      chk("lea we", 1'b1, address_reg_we_o);
      chk("lea sel", i[2:0], address_reg_sel_o);
      chk("lea data", 32'hf0e0_0000 + i, address_reg_wdata_o);
      chk("lea flags", 5'h14, ccr_o);
    end
    // bad modes on all three ops, stalls and both stack layouts
    foreach (bad[i]) begin
      delay_i = i[3:0];
      trap_chk((i % 3 == 0 ? ejt_pkg::JMP_MATCH : i % 3 == 1 ?
        ejt_pkg::CALL_MATCH : ejt_pkg::LEA_MATCH) | bad[i], i[0]);
    end
    trap_chk(ejt_pkg::TRAP_OPCODE, 1'b0);
    trap_chk(ejt_pkg::TRAP_OPCODE, 1'b1);
    ext_word_i = 16'h0111;
    reduced32_core_i = 1'b1;
    trap_chk(ejt_pkg::JMP_MATCH | 16'h30, 1'b0);
    reduced32_core_i = 1'b0;
    issue(ejt_pkg::JMP_MATCH | 16'h30, 32'h0000_4000);
    chk("full jump", 32'h0000_4000, pc_o);
    for (int k = 0; k < 2; k++) begin
      delay_i = k ? 4'h0 : 4'h3;
      s = sp_o;
      next_pc_i = 32'h0000_2460 + k;
      u_mem.log_q.delete();
      issue(ejt_pkg::CALL_MATCH | 16'h3a, 32'h0000_3000 + k);
      n = 0;
      while (pc_load_o !== 1'b1 && n < 40) begin
        @(negedge mclk_i);
        n++;
      end
      chk("call pc", 32'h0000_3000 + k, pc_o);
      chk("call sp", s - 32'h4, sp_o);
      w = u_mem.log_q.pop_front();
      chk("ret addr", s - 32'h4, w.addr);
      chk("ret data", next_pc_i, w.data);
    end
    // reset in the middle of a stalled trap
    delay_i = 4'h8;
    issue(ejt_pkg::TRAP_OPCODE, 32'h0);
    rst_n_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("push in reset", 1'b0, mem_wr_o.valid);
    chk("ssp in reset", 32'h0, supervisor_stack_pointer_o);
    rst_n_i = 1'b1;
    @(negedge mclk_i);
    chk("ready again", 1'b1, op_ready_o);
    // enable low must freeze the block, so a jump is not taken
    ce_i = 1'b0;
    issue(ejt_pkg::JMP_MATCH | 16'h10, 32'h0000_5550);
    chk("frozen load", 1'b0, pc_load_o);
    chk("frozen pc", 32'h0, pc_o);
    ce_i = 1'b1;
    final_report();
  end
endmodule // ejt_exec_bench
